// file: tmr_pkg.sv
// Constants, register indices and field positions for the three-channel timer
package tmr_pkg;
	// Register indices; byte address is four times the index
	localparam logic [11:0] IDX_START = 12'h380;
	localparam logic [11:0] IDX_DIR = 12'h384;
	localparam logic [11:0] IDX_CNT0 = 12'h386;
	localparam logic [11:0] IDX_CNT1 = 12'h388;
	localparam logic [11:0] IDX_CNT2 = 12'h38A;
	localparam logic [11:0] IDX_MODE0 = 12'h396;
	localparam logic [11:0] IDX_MODE1 = 12'h397;
	localparam logic [11:0] IDX_MODE2 = 12'h398;
	localparam logic [11:0] IDX_PCLK = 12'h3A0;
	localparam logic [11:0] IDX_IRQ_STAT = 12'h3A1;
	localparam logic [11:0] IDX_IRQ_MASK = 12'h3A2;
	localparam logic [11:0] IDX_EVT_SRC = 12'h3A3;
	// Field positions of the channel mode register
	localparam int MODE_LSB = 0;
	localparam int PULSE_EN_BIT = 2;
	localparam int EDGE_SEL_BIT = 3;
	localparam int DIR_SRC_BIT = 4;
	localparam int SRC_LSB = 6;
	localparam int FREE_RUN_BIT = 6;
	// Gate function in timer mode: enable and active level
	localparam int GATE_EN_BIT = 4;
	localparam int GATE_LVL_BIT = 3;
	// Writable masks of the shared flag registers
	localparam logic [7:0] START_MASK = 8'hE7;
	localparam logic [7:0] DIR_MASK = 8'h27;
	// Reset values
	localparam logic [7:0] START_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [15:0] CNT_RST = 16'h0000;
	// Prescaler and subclock divide counts
	localparam int SUB_DIV = 32;
	localparam logic [4:0] SUB_LAST = 5'(SUB_DIV - 1);
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	// Operating modes
	typedef enum logic [1:0] {
		MODE_TIMER = 2'b00,
		MODE_EVENT = 2'b01,
		MODE_ONESHOT = 2'b10,
		MODE_PWM = 2'b11
	} mode_t;
	// Internal count source select
	typedef enum logic [1:0] {
		CS_F1F2 = 2'b00,
		CS_F8 = 2'b01,
		CS_F32 = 2'b10,
		CS_SUBCLOCK_DIV32 = 2'b11
	} clk_src_t;
	// Event source select
	typedef enum logic [1:0] {
		EV_PIN = 2'b00,
		EV_TB2 = 2'b01,
		EV_PREV = 2'b10,
		EV_NEXT = 2'b11
	} evt_src_t;
endpackage : tmr_pkg

// file: timer_a_counter_modes.sv
// Three 16-bit timer channels: timer and event counter modes behind APB
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module timer_a_counter_modes (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [13:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Timer pins
	input wire logic [2:0] chan_in,
	input wire logic [2:0] chan_pin_in,
	output logic [2:0] chan_out,
	output logic [2:0] chan_oe,
	// Count sources from outside
	input wire logic subclock,
	input wire logic tb2_event,
	// Interrupt
	output logic irq
);
	typedef struct packed {
		logic [7:0] start;
		logic [7:0] dir;
		logic [2:0][7:0] mode;
		logic [2:0][15:0] cnt;
		logic [2:0][15:0] reload;
		logic [2:0] started;
		logic [2:0] tog;
		logic [2:0] in_prev;
		logic [2:0] wrap;
		logic fast_sel;
		logic [2:0] stat;
		logic [2:0] mask;
		logic [5:0] evt_src;
		logic [4:0] pre;
		logic sub_prev;
		logic [4:0] sub_cnt;
		logic subclock_div32;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic [2:0] out;
		logic [2:0] oe;
		logic irq;
	} state_t;

	state_t s_r;
	state_t s_nxt;
	logic [2:0] tick_c;
	logic [2:0] unf_c;
	logic [2:0] ovf_c;
	logic [2:0] cnt_wr_c;

	// Word index match for an aligned APB address
	function automatic logic hit(input logic [13:0] a, input logic [11:0] idx);
		hit = (a[13:2] == idx) && (a[1:0] == 2'b00);
	endfunction : hit

	// Internal count source tick from prescaler state
	function automatic logic src_tick(input logic [1:0] sel, input logic [4:0] pre,
			input logic fast, input logic subclock_div32);
		logic t;
		t = 1'b0;
		unique case (tmr_pkg::clk_src_t'(sel))
			tmr_pkg::CS_F1F2: t = fast ? (pre[0] == 1'b1) : 1'b1;
			tmr_pkg::CS_F8: t = (pre[2:0] == 3'h7);
			tmr_pkg::CS_F32: t = (pre == 5'h1F);
			tmr_pkg::CS_SUBCLOCK_DIV32: t = subclock_div32;
		endcase
		src_tick = t;
	endfunction : src_tick

	// Next-state logic for bus, prescalers and channels
	always_comb begin
		logic acc;
		logic wr;
		logic [11:0] idx;
		logic mapped;
		logic [31:0] rd;
		tmr_pkg::mode_t md;
		logic up;
		logic ev;
		logic edge_sel;
		logic [2:0] stat_set;
		s_nxt = s_r;
		tick_c = 3'b000;
		unf_c = 3'b000;
		ovf_c = 3'b000;
		cnt_wr_c = 3'b000;
		acc = psel && penable && s_r.ready;
		wr = acc && pwrite;
		idx = paddr[13:2];
		mapped = 1'b0;
		rd = 32'h0000_0000;
		md = tmr_pkg::MODE_TIMER;
		up = 1'b0;
		ev = 1'b0;
		edge_sel = 1'b0;
		stat_set = 3'b000;
		// Free-running prescaler and subclock divider
		s_nxt.pre = s_r.pre + 5'h01;
		s_nxt.sub_prev = subclock;
		s_nxt.subclock_div32 = 1'b0;
		if (subclock && !s_r.sub_prev) begin
			s_nxt.sub_cnt = (s_r.sub_cnt == tmr_pkg::SUB_LAST) ? 5'h00 : s_r.sub_cnt + 5'h01;
			s_nxt.subclock_div32 = (s_r.sub_cnt == tmr_pkg::SUB_LAST);
		end
		// Register writes other than the count registers
		if (wr) begin
			if (hit(paddr, tmr_pkg::IDX_START))
				s_nxt.start = pwdata[7:0] & tmr_pkg::START_MASK;
			if (hit(paddr, tmr_pkg::IDX_DIR))
				s_nxt.dir = pwdata[7:0] & tmr_pkg::DIR_MASK;
			if (hit(paddr, tmr_pkg::IDX_MODE0))
				s_nxt.mode[0] = pwdata[7:0];
			if (hit(paddr, tmr_pkg::IDX_MODE1))
				s_nxt.mode[1] = pwdata[7:0];
			if (hit(paddr, tmr_pkg::IDX_MODE2))
				s_nxt.mode[2] = pwdata[7:0];
			if (hit(paddr, tmr_pkg::IDX_PCLK))
				s_nxt.fast_sel = pwdata[0];
			if (hit(paddr, tmr_pkg::IDX_IRQ_MASK))
				s_nxt.mask = pwdata[2:0];
			if (hit(paddr, tmr_pkg::IDX_EVT_SRC))
				s_nxt.evt_src = pwdata[5:0];
			cnt_wr_c[0] = hit(paddr, tmr_pkg::IDX_CNT0);
			cnt_wr_c[1] = hit(paddr, tmr_pkg::IDX_CNT1);
			cnt_wr_c[2] = hit(paddr, tmr_pkg::IDX_CNT2);
		end
		// Per-channel counting
		for (int i = 0; i < 3; i++) begin
			md = tmr_pkg::mode_t'(s_r.mode[i][tmr_pkg::MODE_LSB +: 2]);
			edge_sel = s_r.mode[i][tmr_pkg::EDGE_SEL_BIT];
			s_nxt.in_prev[i] = chan_in[i];
			// Direction from flag or from the output pin used as input
			up = s_r.mode[i][tmr_pkg::DIR_SRC_BIT] ? chan_pin_in[i] : s_r.dir[i];
			// Event source selection
			unique case (tmr_pkg::evt_src_t'(s_r.evt_src[2*i +: 2]))
				tmr_pkg::EV_PIN: ev = edge_sel ? (chan_in[i] && !s_r.in_prev[i]) :
					(!chan_in[i] && s_r.in_prev[i]);
				tmr_pkg::EV_TB2: ev = tb2_event;
				tmr_pkg::EV_PREV: ev = (i > 0) ? s_r.wrap[(i + 2) % 3] : 1'b0;
				tmr_pkg::EV_NEXT: ev = (i < 2) ? s_r.wrap[(i + 1) % 3] : 1'b0;
			endcase
			unique case (md)
				tmr_pkg::MODE_TIMER: tick_c[i] = src_tick(s_r.mode[i][tmr_pkg::SRC_LSB +: 2],
					s_r.pre, s_r.fast_sel, s_r.subclock_div32) &&
					(!s_r.mode[i][tmr_pkg::GATE_EN_BIT] ||
					(chan_in[i] == s_r.mode[i][tmr_pkg::GATE_LVL_BIT]));
				tmr_pkg::MODE_EVENT: tick_c[i] = ev;
				tmr_pkg::MODE_ONESHOT, tmr_pkg::MODE_PWM: tick_c[i] = 1'b0;
			endcase
			tick_c[i] = tick_c[i] && s_r.start[i];
			s_nxt.wrap[i] = 1'b0;
			if (!s_r.start[i]) begin
				s_nxt.started[i] = 1'b0;
				s_nxt.tog[i] = 1'b0;
			end else if (tick_c[i]) begin
				s_nxt.started[i] = 1'b1;
				if (md == tmr_pkg::MODE_EVENT && up) begin
					if (s_r.cnt[i] == tmr_pkg::CNT_MAX) begin
						ovf_c[i] = 1'b1;
						s_nxt.cnt[i] = s_r.mode[i][tmr_pkg::FREE_RUN_BIT] ? 16'h0000 :
							s_r.reload[i];
					end else begin
						s_nxt.cnt[i] = s_r.cnt[i] + 16'h0001;
					end
				end else begin
					if (s_r.cnt[i] == 16'h0000) begin
						unf_c[i] = 1'b1;
						s_nxt.cnt[i] = (md == tmr_pkg::MODE_EVENT &&
							s_r.mode[i][tmr_pkg::FREE_RUN_BIT]) ?
							tmr_pkg::CNT_MAX : s_r.reload[i];
					end else begin
						s_nxt.cnt[i] = s_r.cnt[i] - 16'h0001;
					end
				end
				if (unf_c[i] || ovf_c[i]) begin
					s_nxt.tog[i] = !s_r.tog[i];
					s_nxt.wrap[i] = 1'b1;
				end
			end
			// Count register write: both before the first tick, else reload only
			if (cnt_wr_c[i]) begin
				s_nxt.reload[i] = pwdata[15:0];
				if (!s_r.start[i] || !s_r.started[i])
					s_nxt.cnt[i] = pwdata[15:0];
			end
			// Interrupt source per mode
			stat_set[i] = (md == tmr_pkg::MODE_TIMER) ? unf_c[i] :
				((md == tmr_pkg::MODE_EVENT) ? (unf_c[i] || ovf_c[i]) : 1'b0);
			// Pulse output pin; pin is input when used as direction source
			s_nxt.out[i] = s_r.mode[i][tmr_pkg::PULSE_EN_BIT] && s_nxt.start[i] &&
				(md == tmr_pkg::MODE_TIMER || md == tmr_pkg::MODE_EVENT) &&
				s_nxt.tog[i];
			s_nxt.oe[i] = s_r.mode[i][tmr_pkg::PULSE_EN_BIT] &&
				!(md == tmr_pkg::MODE_EVENT && s_r.mode[i][tmr_pkg::DIR_SRC_BIT]);
		end
		// Sticky status: set wins over write-one-to-clear
		if (wr && hit(paddr, tmr_pkg::IDX_IRQ_STAT))
			s_nxt.stat = s_r.stat & ~pwdata[2:0];
		s_nxt.stat = s_nxt.stat | stat_set;
		s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
		// Read mux, answered in the first access cycle
		mapped = 1'b1;
		unique case (idx)
			tmr_pkg::IDX_START: rd = {24'h000000, s_r.start};
			tmr_pkg::IDX_DIR: rd = {24'h000000, s_r.dir};
			tmr_pkg::IDX_CNT0: rd = {16'h0000, s_r.cnt[0]};
			tmr_pkg::IDX_CNT1: rd = {16'h0000, s_r.cnt[1]};
			tmr_pkg::IDX_CNT2: rd = {16'h0000, s_r.cnt[2]};
			tmr_pkg::IDX_MODE0: rd = {24'h000000, s_r.mode[0]};
			tmr_pkg::IDX_MODE1: rd = {24'h000000, s_r.mode[1]};
			tmr_pkg::IDX_MODE2: rd = {24'h000000, s_r.mode[2]};
			tmr_pkg::IDX_PCLK: rd = {31'h00000000, s_r.fast_sel};
			tmr_pkg::IDX_IRQ_STAT: rd = {29'h00000000, s_r.stat};
			tmr_pkg::IDX_IRQ_MASK: rd = {29'h00000000, s_r.mask};
			tmr_pkg::IDX_EVT_SRC: rd = {26'h0000000, s_r.evt_src};
			default: mapped = 1'b0;
		endcase
		mapped = mapped && (paddr[1:0] == 2'b00);
		s_nxt.ready = psel && !penable;
		s_nxt.err = psel && !penable && !mapped;
		s_nxt.rdata = (psel && !penable && !pwrite && mapped) ? rd : 32'h0000_0000;
	end

	// State register
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s_r <= '0;
			s_r.start <= tmr_pkg::START_RST;
			s_r.dir <= tmr_pkg::DIR_RST;
			s_r.mode <= {3{tmr_pkg::MODE_RST}};
			s_r.cnt <= {3{tmr_pkg::CNT_RST}};
			s_r.reload <= {3{tmr_pkg::CNT_RST}};
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from flops
	assign prdata = s_r.rdata;
	assign pready = s_r.ready;
	assign pslverr = s_r.err;
	assign chan_out = s_r.out;
	assign chan_oe = s_r.oe;
	assign irq = s_r.irq;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	// Bus answers in the first access cycle
	apb_ready_a: assert property (psel && !penable |=> pready)
		else $error("APB not ready in access cycle");
	// Misaligned access flagged as unmapped
	unmapped_err_a: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
		else $error("Misaligned access not flagged");
	// Stopped channel drives low
	stop_low_a: assert property (!s_r.start[0] |-> !chan_out[0])
		else $error("Output high while stopped");
	// Timer underflow reloads
	timer_reload_a: assert property (unf_c[1] && !cnt_wr_c[1] &&
		s_r.mode[1][1:0] == 2'b00 |=> s_r.cnt[1] == $past(s_r.reload[1]))
		else $error("Counter not reloaded on underflow");
	// Down count decrements by one
	timer_dec_a: assert property (tick_c[0] && s_r.cnt[0] != 16'h0000 && !cnt_wr_c[0] &&
		!(s_r.mode[0][1:0] == 2'b01 && ovf_c[0]) && !(s_r.mode[0][1:0] == 2'b01 &&
		(s_r.mode[0][4] ? chan_pin_in[0] : s_r.dir[0]))
		|=> s_r.cnt[0] == $past(s_r.cnt[0]) - 16'h0001)
		else $error("Counter did not step down");
	// Write while stopped loads counter
	stop_write_a: assert property (cnt_wr_c[2] && !s_r.start[2]
		|=> s_r.cnt[2] == $past(pwdata[15:0]) && s_r.reload[2] == $past(pwdata[15:0]))
		else $error("Stopped write missed counter");
	// Write while running leaves counter alone
	run_write_a: assert property (cnt_wr_c[1] && s_r.start[1] && s_r.started[1] &&
		!tick_c[1] |=> $stable(s_r.cnt[1]))
		else $error("Running write touched counter");
	// Event flags become sticky status and interrupt
	irq_sticky_a: assert property ((unf_c[0] || ovf_c[0]) && s_r.mode[0][1] == 1'b0
		|=> s_r.stat[0] ##0 (irq || !s_r.mask[0]))
		else $error("Event did not raise interrupt");
	// PWM with zero count stays low
	pwm_zero_a: assert property (s_r.mode[2][1:0] == 2'b11 && s_r.reload[2] == 16'h0000
		|=> !chan_out[2] && (!s_r.stat[2] || $past(s_r.stat[2])))
		else $error("PWM zero count not quiet");
	// Gate closed stops the count
	gate_hold_a: assert property (s_r.mode[0][1:0] == 2'b00 && s_r.mode[0][4] &&
		chan_in[0] != s_r.mode[0][3] |-> !tick_c[0])
		else $error("Gate did not stop counting");

	// Ready is a single-cycle answer
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("Ready held for more than one cycle");
	// Read data is zero outside the answer cycle
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("Read data not zero while idle");

	// Stopping clears the first-tick marker
	stop_clear_a: assert property (!s_r.start[1] |=> !s_r.started[1])
		else $error("First-tick marker kept while stopped");
	// Stopped channel holds its count
	stopped_hold_a: assert property (!s_r.start[2] && !cnt_wr_c[2] |=> $stable(s_r.cnt[2]))
		else $error("Stopped channel changed its count");
	// Timer mode never counts up
	timer_no_up_a: assert property (s_r.mode[0][1:0] == 2'b00 |-> !ovf_c[0])
		else $error("Overflow seen in timer mode");

	// Event up count from the direction flag
	event_up_a: assert property (s_r.mode[1][1:0] == 2'b01 && !s_r.mode[1][4] &&
		s_r.dir[1] && tick_c[1] && s_r.cnt[1] != 16'hFFFF && !cnt_wr_c[1]
		|=> s_r.cnt[1] == $past(s_r.cnt[1]) + 16'h0001)
		else $error("Event counter did not step up");
	// Event down count from the direction flag
	event_down_a: assert property (s_r.mode[1][1:0] == 2'b01 && !s_r.mode[1][4] &&
		!s_r.dir[1] && tick_c[1] && s_r.cnt[1] != 16'h0000 && !cnt_wr_c[1]
		|=> s_r.cnt[1] == $past(s_r.cnt[1]) - 16'h0001)
		else $error("Event counter did not step down");
	// Reload type reloads on overflow
	event_reload_a: assert property (s_r.mode[1][1:0] == 2'b01 && !s_r.mode[1][6] &&
		ovf_c[1] && !cnt_wr_c[1] |=> s_r.cnt[1] == $past(s_r.reload[1]))
		else $error("Event counter not reloaded on overflow");
	// Free-run wraps down to all ones
	free_wrap_a: assert property (s_r.mode[1][1:0] == 2'b01 && s_r.mode[1][6] &&
		unf_c[1] && !cnt_wr_c[1] |=> s_r.cnt[1] == 16'hFFFF)
		else $error("Free-run underflow did not wrap");
	// Pin high selects up count
	pin_dir_a: assert property (s_r.mode[1][1:0] == 2'b01 && s_r.mode[1][4] &&
		chan_pin_in[1] && tick_c[1] && s_r.cnt[1] != 16'hFFFF && !cnt_wr_c[1]
		|=> s_r.cnt[1] == $past(s_r.cnt[1]) + 16'h0001)
		else $error("Pin direction did not count up");
	// Pin used as direction input is not driven
	oe_pin_a: assert property (s_r.mode[1][1:0] == 2'b01 && s_r.mode[1][4] |=> !chan_oe[1])
		else $error("Direction pin driven as output");

	// Every wrap inverts the pulse level
	pulse_toggle_a: assert property ((unf_c[0] || ovf_c[0])
		|=> s_r.tog[0] != $past(s_r.tog[0]))
		else $error("Pulse level not inverted on wrap");
	// Interrupt line follows unmasked status
	irq_level_a: assert property (irq == |(s_r.stat & s_r.mask))
		else $error("Interrupt line disagrees with status");
	// Status stays set until written with one
	sticky_hold_a: assert property (s_r.stat[2] &&
		!(psel && penable && pready && pwrite && pwdata[2]) |=> s_r.stat[2])
		else $error("Status bit lost without clear");

	// Rising pin edge counted when selected
	edge_rise_a: assert property (s_r.mode[1][1:0] == 2'b01 && s_r.evt_src[3:2] == 2'b00 &&
		s_r.start[1] && s_r.mode[1][3] && chan_in[1] && !s_r.in_prev[1] |-> tick_c[1])
		else $error("Rising edge not counted");
	// Falling pin edge counted when selected
	edge_fall_a: assert property (s_r.mode[1][1:0] == 2'b01 && s_r.evt_src[3:2] == 2'b00 &&
		s_r.start[1] && !s_r.mode[1][3] && !chan_in[1] && s_r.in_prev[1] |-> tick_c[1])
		else $error("Falling edge not counted");
	// Timer B2 wrap counted when selected
	tb2_src_a: assert property (s_r.mode[2][1:0] == 2'b01 && s_r.evt_src[5:4] == 2'b01 &&
		s_r.start[2] && tb2_event |-> tick_c[2])
		else $error("Timer B2 event not counted");
	// One-shot and PWM do not count here
	pwm_idle_a: assert property (s_r.mode[2][1] |-> !tick_c[2] && !unf_c[2])
		else $error("Channel counted in one-shot or PWM mode");
	// PWM output held low
	pwm_low_a: assert property (s_r.mode[2][1:0] == 2'b11 |=> !chan_out[2])
		else $error("PWM output not low");
endmodule : timer_a_counter_modes
`default_nettype wire

// file: pulse_src.sv
// External pulse sources and direction levels around the timer channels
`timescale 1ns/10ps
`default_nettype none
module pulse_src (
	// Clock
	input wire logic ref_clk,
	// Lines into the timer
	output logic [2:0] chan_in,
	output logic [2:0] chan_pin_in,
	output logic subclock,
	output logic tb2_event
);
	// Idle levels at time zero
	initial begin
		chan_in = 3'h0;
		chan_pin_in = 3'h0;
		tb2_event = 1'b0;
	end
	// Slow subclock, one level every three cycles
	initial begin
		subclock = 1'b0;
		forever begin
			repeat (3) @(posedge ref_clk);
			subclock <= ~subclock;
		end
	end
	// One pulse on a channel pin, or a one-cycle wrap pulse when ch is 3
	task automatic pulse(input int ch, input int hold);
		@(posedge ref_clk);
		if (ch == 3) begin
			tb2_event <= 1'b1;
		end else begin
			chan_in[ch] <= 1'b1;
		end
		repeat (ch == 3 ? 1 : hold) @(posedge ref_clk);
		if (ch == 3) begin
			tb2_event <= 1'b0;
		end else begin
			chan_in[ch] <= 1'b0;
		end
		repeat (hold) @(posedge ref_clk);
	endtask : pulse
	// Level seen on a channel output pin used as direction input
	task automatic pin_dir(input int ch, input logic v);
		@(posedge ref_clk);
		chan_pin_in[ch] <= v;
	endtask : pin_dir
endmodule : pulse_src
`default_nettype wire

// file: timer_a_counter_modes_bench.sv
// Self-checking bench for the three-channel timer
`timescale 1ns/10ps
`default_nettype none
module timer_a_counter_modes_bench;
	logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, subclock, tb2_event, irq, err;
	logic [13:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] chan_in, chan_pin_in, chan_out, chan_oe;
	logic [7:0] lfsr;
	int mismatches, total_checks, n, cyc, i, mdl, rel;
	bit up, free;
	localparam int SRC[5] = '{0, 0, 1, 2, 3};
	localparam int DIV[5] = '{1, 2, 8, 32, 192};
	// Design and far-side sources
	timer_a_counter_modes i_timer_a_counter_modes (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .chan_in(chan_in), .chan_pin_in(chan_pin_in),
		.chan_out(chan_out), .chan_oe(chan_oe), .subclock(subclock), .tb2_event(tb2_event),
		.irq(irq));
	pulse_src i_pulse_src (.ref_clk(ref_clk), .chan_in(chan_in), .chan_pin_in(chan_pin_in),
		.subclock(subclock), .tb2_event(tb2_event));
	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	function automatic int rnd();
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return int'(lfsr);
	endfunction : rnd
	// One APB transfer; read data and error taken at the pready edge
	task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
		int k;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1) begin
			mismatches++;
			report_and_stop();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdc(input logic [11:0] idx, input logic [31:0] exp, input string what);
		apb(1'b0, idx, 32'h0);
		chk(what, exp, rd);
	endtask : rdc
	// Cycles until the pulse output changes
	task automatic wait_change(input int ch);
		logic old;
		old = chan_out[ch];
		cyc = 0;
		while (chan_out[ch] === old) begin
			@(posedge ref_clk);
			cyc++;
			if (cyc > 9000) begin
				mismatches++;
				report_and_stop();
			end
		end
	endtask : wait_change
	// Source pulses stepped through the counter model, then a live read
	task automatic ev(input int ch, input logic [11:0] idx, input int cnt);
		repeat (cnt) begin
			i_pulse_src.pulse(ch, 2 + rnd() % 3);
			if (up) begin
				mdl = (mdl == 16'hFFFF) ? (free ? 0 : rel) : mdl + 1;
			end else begin
				mdl = (mdl == 0) ? (free ? 16'hFFFF : rel) : mdl - 1;
			end
		end
		repeat (4) @(posedge ref_clk);
		rdc(idx, 32'(mdl), "count");
	endtask : ev
	task automatic arm(input logic [11:0] mi, input int m, input logic [11:0] ci, input int v);
		apb(1'b1, tmr_pkg::IDX_START, 32'h0);
		apb(1'b1, mi, 32'(m));
		apb(1'b1, ci, 32'(v));
		rel = v;
		mdl = v;
	endtask : arm
	// Main sequence
	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 14'h0000;
		pwdata = 32'h0;
		lfsr = 8'h52;
		mismatches = 0;
		total_checks = 0;
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		rdc(tmr_pkg::IDX_START, 32'h0, "start reset");
		rdc(tmr_pkg::IDX_DIR, 32'h0, "dir reset");
		rdc(tmr_pkg::IDX_MODE0, 32'h0, "mode reset");
		apb(1'b0, 12'h3FF, 32'h0);
		chk("unmapped err", 32'h1, 32'(err));
		apb(1'b1, tmr_pkg::IDX_START, 32'hFF);
		rdc(tmr_pkg::IDX_START, 32'hE7, "start mask");
		apb(1'b1, tmr_pkg::IDX_START, 32'h0);
		apb(1'b1, tmr_pkg::IDX_DIR, 32'h07);
		rdc(tmr_pkg::IDX_DIR, 32'h07, "dir flags");
		apb(1'b1, tmr_pkg::IDX_IRQ_STAT, 32'h7);
		$display("Test registers finished");
		for (i = 0; i < 5; i++) begin
			n = 1 + rnd() % 4;
			arm(tmr_pkg::IDX_MODE0, 32'h04 | (SRC[i] << 6), tmr_pkg::IDX_CNT0, n);
			apb(1'b1, tmr_pkg::IDX_PCLK, 32'(i == 1));
			apb(1'b1, tmr_pkg::IDX_START, 32'h01);
			wait_change(0);
			wait_change(0);
			chk("period", 32'(DIV[i] * (n + 1)), 32'(cyc));
			chk("oe", 32'h1, 32'(chan_oe[0]));
			apb(1'b1, tmr_pkg::IDX_START, 32'h0);
			repeat (3) @(posedge ref_clk);
			chk("out stopped", 32'h0, 32'(chan_out[0]));
		end
		rdc(tmr_pkg::IDX_IRQ_STAT, 32'h1, "stat");
		chk("irq masked", 32'h0, 32'(irq));
		apb(1'b1, tmr_pkg::IDX_IRQ_MASK, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk("irq", 32'h1, 32'(irq));
		apb(1'b1, tmr_pkg::IDX_IRQ_STAT, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk("irq cleared", 32'h0, 32'(irq));
		$display("Test timer mode finished");
		arm(tmr_pkg::IDX_MODE1, 32'h09, tmr_pkg::IDX_CNT1, 16'hFFFD);
		apb(1'b1, tmr_pkg::IDX_DIR, 32'h02);
		up = 1;
		free = 0;
		apb(1'b1, tmr_pkg::IDX_START, 32'h02);
		ev(1, tmr_pkg::IDX_CNT1, 4);
		rdc(tmr_pkg::IDX_IRQ_STAT, 32'h2, "overflow stat");
		apb(1'b1, tmr_pkg::IDX_CNT1, 32'h10);
		rel = 16'h10;
		ev(1, tmr_pkg::IDX_CNT1, 0);
		ev(1, tmr_pkg::IDX_CNT1, 2);
		arm(tmr_pkg::IDX_MODE1, 32'h41, tmr_pkg::IDX_CNT1, 1);
		apb(1'b1, tmr_pkg::IDX_DIR, 32'h0);
		up = 0;
		free = 1;
		apb(1'b1, tmr_pkg::IDX_START, 32'h02);
		ev(1, tmr_pkg::IDX_CNT1, 3);
		apb(1'b1, tmr_pkg::IDX_MODE1, 32'h51);
		i_pulse_src.pin_dir(1, 1'b1);
		up = 1;
		ev(1, tmr_pkg::IDX_CNT1, 2);
		i_pulse_src.pin_dir(1, 1'b0);
		up = 0;
		ev(1, tmr_pkg::IDX_CNT1, 1);
		$display("Test event mode finished");
		arm(tmr_pkg::IDX_MODE2, 32'h01, tmr_pkg::IDX_CNT2, 5);
		apb(1'b1, tmr_pkg::IDX_EVT_SRC, 32'h10);
		free = 0;
		apb(1'b1, tmr_pkg::IDX_START, 32'h04);
		ev(3, tmr_pkg::IDX_CNT2, 3);
		arm(tmr_pkg::IDX_MODE0, 32'h18, tmr_pkg::IDX_CNT0, 32'h20);
		apb(1'b1, tmr_pkg::IDX_START, 32'h01);
		repeat (20) @(posedge ref_clk);
		rdc(tmr_pkg::IDX_CNT0, 32'h20, "gate closed");
		i_pulse_src.pulse(0, 3);
		rdc(tmr_pkg::IDX_CNT0, 32'h1D, "gate open");
		arm(tmr_pkg::IDX_MODE2, 32'h07, tmr_pkg::IDX_CNT2, 0);
		apb(1'b1, tmr_pkg::IDX_IRQ_STAT, 32'h7);
		apb(1'b1, tmr_pkg::IDX_START, 32'h04);
		repeat (40) @(posedge ref_clk);
		chk("pwm out", 32'h0, 32'(chan_out[2]));
		rdc(tmr_pkg::IDX_IRQ_STAT, 32'h0, "pwm stat");
		$display("Test sources, gate and pwm finished");
		report_and_stop();
	end
endmodule : timer_a_counter_modes_bench
`default_nettype wire
